// File: motion_cycle_ctrl.v
// Motion operation cycle scheduler, run-ready sequencer, forced stop and
// latch ranges, with an APB register slave. Assumes one clock pclk at
// 125 MHz; run switch, forced-stop pin and latch-clear key are asynchronous.
// Notes on behaviour
// [R1] Period selectable among five values or automatic
// [R2] Real periods slightly longer than labels
// [R3] Automatic default; positioning axis-count table
// [R4] Virtual mode uses its own axis table
// [R5] Overrun flag when computation exceeds period
// [R6] Duration and active period readable in us
// [R7] No-short amplifier turns 0.8 into 1.7
// [R8] Software picks 3.5 for old amplifiers
// [R9] Vector inverter raises 0.8 and 1.7 to 3.5 ms
// [R10] Ready rule: switch only or register
// [R11] Switch mode: ready rises at run
// [R12] Ready falls when switch goes to stop
// [R13] Register mode: bit zero rise raises ready
// [R14] Register mode: bit zero fall drops ready
// [R15] Forced-stop source low stops all axes
// [R16] Forced-stop source high releases axes
// [R17] Software must choose forced-stop source
// [R18] Two latch ranges, one survives clear key
// [R19] Period from cycle count, start pulse each
// [R20] Overrun flag sticky until reset
`timescale 1ns/1ps
`include "motion_cycle_defines.vh"

module motion_cycle_ctrl
#(
  parameter PER0_CYC = `PER0_CYC,
  parameter PER1_CYC = `PER1_CYC,
  parameter PER2_CYC = `PER2_CYC,
  parameter PER3_CYC = `PER3_CYC,
  parameter PER4_CYC = `PER4_CYC,
  parameter US_CYC = `US_CYC
)
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire run_switch,
  input wire external_input_bit,
  input wire latch_clear_key,
  input wire compute_done,
  output reg compute_start,
  output reg run_ready_flag,
  output reg axes_stop,
  output reg latch_erase,
  output reg [15:0] latch_erase_first,
  output reg [15:0] latch_erase_last
);

  reg [15:0] ctrl;
  reg [5:0] axes;
  reg ready_setting_register;
  reg [31:0] latch_ranges;
  reg period_overrun_flag;
  reg [15:0] measured_compute_time, active_period_value;
  reg [2:0] active_sel, next_sel, auto_sel;
  reg [23:0] cyc_cnt, cyc_term;
  reg busy;
  reg [15:0] us_cnt;
  reg [7:0] us_div;
  reg [1:0] sw_sync, es_sync, key_sync;
  reg sw_prev, key_prev, rdy_prev;
  reg [23:0] next_term;
  reg [15:0] next_us;
  reg [31:0] rd_mux;
  reg rd_ok;
  wire [2:0] user_sel;
  wire sw_run, access;

  assign user_sel = ctrl[`CTRL_SEL_LSB+2:`CTRL_SEL_LSB];
  assign sw_run = sw_sync[1];
  assign access = psel & penable & pready;

  // Automatic choice from axis count and operating system
  always @*
  begin
    if (ctrl[`CTRL_VIRT_BIT])
    begin
      if (axes <= 6'd4)
        auto_sel = `SEL_0P8; // [R4]
      else if (axes <= 6'd12)
        auto_sel = `SEL_1P7;
      else if (axes <= 6'd24)
        auto_sel = `SEL_3P5;
      else
        auto_sel = `SEL_7P1;
    end
    else
    begin
      if (axes <= 6'd8)
        auto_sel = `SEL_0P8; // [R3]
      else if (axes <= 6'd16)
        auto_sel = `SEL_1P7;
      else
        auto_sel = `SEL_3P5;
    end
  end

  // Effective selection after amplifier substitutions
  always @*
  begin
    next_sel = (user_sel == `SEL_AUTO) ? auto_sel : user_sel; // [R1]
    if (next_sel > `SEL_14P2)
      next_sel = `SEL_14P2;
    if (ctrl[`CTRL_NOSHORT_BIT] && next_sel == `SEL_0P8)
      next_sel = `SEL_1P7; // [R7]
    if (ctrl[`CTRL_VINV_BIT] && next_sel <= `SEL_1P7)
      next_sel = `SEL_3P5; // [R9]
  end

  // Terminal count and microsecond figure of the chosen period
  always @*
  begin
    case (next_sel)
      `SEL_0P8: next_term = PER0_CYC[23:0] - 24'h00_0001; // [R2]
      `SEL_1P7: next_term = PER1_CYC[23:0] - 24'h00_0001;
      `SEL_3P5: next_term = PER2_CYC[23:0] - 24'h00_0001;
      `SEL_7P1: next_term = PER3_CYC[23:0] - 24'h00_0001;
      default: next_term = PER4_CYC[23:0] - 24'h00_0001;
    endcase
    case (next_sel)
      `SEL_0P8: next_us = 16'h0378; // 888 us [R6]
      `SEL_1P7: next_us = 16'h06F1; // 1777 us
      `SEL_3P5: next_us = 16'h0DE3; // 3555 us
      `SEL_7P1: next_us = 16'h1BC7; // 7111 us
      default: next_us = 16'h378E; // 14222 us
    endcase
  end

  // Input synchronisers; only the second stage is used downstream
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sw_sync <= 2'b00;
      es_sync <= 2'b00;
      key_sync <= 2'b00;
    end
    else
    begin
      sw_sync <= {sw_sync[0], run_switch};
      es_sync <= {es_sync[0], external_input_bit};
      key_sync <= {key_sync[0], latch_clear_key};
    end
  end

  // Period counter; a new selection is adopted only at a period boundary
  // so a running cycle is never cut short.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cyc_cnt <= 24'h00_0000;
      cyc_term <= 24'h00_0000;
      active_sel <= `SEL_0P8;
      active_period_value <= 16'h0000;
      compute_start <= 1'b0;
    end
    else
    begin
      compute_start <= 1'b0;
      if (cyc_cnt >= cyc_term)
      begin
        cyc_cnt <= 24'h00_0000;
        cyc_term <= next_term; // [R19]
        active_sel <= next_sel;
        active_period_value <= next_us; // [R6]
        compute_start <= 1'b1; // [R19]
      end
      else
        cyc_cnt <= cyc_cnt + 24'h00_0001;
    end
  end

  // Computation timing in us; overrun when a new start finds it busy
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy <= 1'b0;
      us_cnt <= 16'h0000;
      us_div <= 8'h00;
      measured_compute_time <= 16'h0000;
      period_overrun_flag <= 1'b0;
    end
    else
    begin
      if (compute_start)
      begin
        if (busy && !compute_done)
          period_overrun_flag <= 1'b1; // [R5] [R20]
        busy <= 1'b1;
        us_cnt <= 16'h0000;
        us_div <= 8'h00;
      end
      else if (busy)
      begin
        if (compute_done)
        begin
          busy <= 1'b0;
          measured_compute_time <= us_cnt; // [R6]
        end
        if (us_div == US_CYC[7:0] - 8'h01)
        begin
          us_div <= 8'h00;
          if (us_cnt != 16'hFFFF)
            us_cnt <= us_cnt + 16'h0001;
        end
        else
          us_div <= us_div + 8'h01;
      end
    end
  end

  // Run-ready sequencing; switch reset value of stop makes a switch
  // already at run after reset look like a stop-to-run change.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sw_prev <= 1'b0;
      rdy_prev <= 1'b0;
      run_ready_flag <= 1'b0;
    end
    else
    begin
      sw_prev <= sw_run;
      rdy_prev <= ready_setting_register;
      if (!sw_run && sw_prev)
        run_ready_flag <= 1'b0; // [R12]
      else if (!ctrl[`CTRL_RMODE_BIT])
      begin
        if (sw_run && !sw_prev)
          run_ready_flag <= 1'b1; // [R10] [R11]
      end
      else if (sw_run)
      begin
        if (ready_setting_register && !rdy_prev)
          run_ready_flag <= 1'b1; // [R13]
        else if (!ready_setting_register && rdy_prev)
          run_ready_flag <= 1'b0; // [R14]
      end
    end
  end

  // Forced stop, active low on the chosen source; stop at reset,
  // after which the pin is the source until software picks the register.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      axes_stop <= 1'b1;
    else if (ctrl[`CTRL_ESRC_BIT])
      axes_stop <= ~ctrl[`CTRL_RELAY_BIT]; // [R15] [R16] [R17]
    else
      axes_stop <= ~es_sync[1]; // [R15] [R16]
  end

  // Latch-clear key erases only the first range; second range survives
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      key_prev <= 1'b0;
      latch_erase <= 1'b0;
      latch_erase_first <= 16'h0000;
      latch_erase_last <= 16'h0000;
    end
    else
    begin
      key_prev <= key_sync[1];
      latch_erase <= key_sync[1] & ~key_prev; // [R18]
      latch_erase_first <= {8'h00, latch_ranges[7:0]};
      latch_erase_last <= {8'h00, latch_ranges[15:8]}; // [R18]
    end
  end

  // Read decode
  always @*
  begin
    rd_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `OFS_CTRL: rd_mux = {16'h0000, ctrl};
      `OFS_AXES: rd_mux = {26'h000_0000, axes};
      `OFS_READY: rd_mux = {31'h0000_0000, ready_setting_register};
      `OFS_STATUS: rd_mux = {25'h000_0000, active_sel, axes_stop, busy,
        run_ready_flag, period_overrun_flag};
      `OFS_MEAS: rd_mux = {16'h0000, measured_compute_time};
      `OFS_ACTIVE: rd_mux = {16'h0000, active_period_value};
      `OFS_LATCH: rd_mux = latch_ranges;
      default: rd_ok = 1'b0;
    endcase
  end

  // APB slave: one wait state, answer registered
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      ctrl <= `CTRL_RST; // [R3]
      axes <= `AXES_RST;
      ready_setting_register <= 1'b0;
      latch_ranges <= `LATCH_RST;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      // Answer fields are zero outside the answer cycle
      pslverr <= psel & penable & ~pready & ~rd_ok;
      prdata <= (psel & penable & ~pready & ~pwrite) ? rd_mux : 32'h0000_0000;
      if (access && pwrite && rd_ok)
      begin
        case (paddr)
          `OFS_CTRL: ctrl <= {6'h00, pwdata[9:0]}; // [R1] [R10]
          `OFS_AXES: axes <= pwdata[5:0];
          `OFS_READY: ready_setting_register <= pwdata[0];
          `OFS_LATCH: latch_ranges <= pwdata; // [R18]
          default: ctrl <= ctrl;
        endcase
      end
    end
  end

endmodule // motion_cycle_ctrl

// File: motion_cycle_ctrl_chk.sv
// Port-level properties of the motion cycle block.
// Assumes the stop source stays on the pin and periods of 50 cycles or more.
`timescale 1ns/1ps
module motion_cycle_ctrl_chk
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire [31:0] prdata,
  input wire run_switch,
  input wire external_input_bit,
  input wire latch_clear_key,
  input wire compute_start,
  input wire run_ready_flag,
  input wire axes_stop,
  input wire latch_erase
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Pins pass a two-stage sync, so allow a few cycles of settling
  a_start_gap: assert property (compute_start |=> !compute_start [*8])
    else $error("start pulses too close");
  a_ready_fall: assert property (!run_switch [*5] |-> !run_ready_flag)
    else $error("ready kept at stop");
  a_ready_cause: assert property ($rose(run_ready_flag) |-> run_switch)
    else $error("ready rose at stop");
  a_stop_on: assert property (!external_input_bit [*6] |-> axes_stop)
    else $error("axes not stopped");
  a_stop_off: assert property (external_input_bit [*6] |-> !axes_stop)
    else $error("axes not released");
  a_erase_key: assert property (latch_erase |-> latch_clear_key ##1 !latch_erase)
    else $error("erase pulse wrong");
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("late answer");
  a_err_with: assert property (pslverr |-> pready && psel && penable)
    else $error("stray error");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");
endmodule // motion_cycle_ctrl_chk

bind motion_cycle_ctrl motion_cycle_ctrl_chk chk (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .prdata, .run_switch, .external_input_bit, .latch_clear_key, .compute_start,
  .run_ready_flag, .axes_stop, .latch_erase);

// File: motion_cycle_defines.vh
// Constants for the motion cycle and run-ready control block.
// Included by motion_cycle_ctrl.v; definitions only.
`ifndef MOTION_CYCLE_DEFINES_VH
`define MOTION_CYCLE_DEFINES_VH

// Clock period of pclk in ns
`define CLK_NS 8
// Real operation periods in ns, nominal 0.8/1.7/3.5/7.1/14.2 ms
`define PER0_NS 888889
`define PER1_NS 1777778
`define PER2_NS 3555556
`define PER3_NS 7111111
`define PER4_NS 14222222
// Cycle counts derived from the periods (rounded down)
`define PER0_CYC (`PER0_NS / `CLK_NS)
`define PER1_CYC (`PER1_NS / `CLK_NS)
`define PER2_CYC (`PER2_NS / `CLK_NS)
`define PER3_CYC (`PER3_NS / `CLK_NS)
`define PER4_CYC (`PER4_NS / `CLK_NS)
// Microsecond length in ns and derived cycles
`define US_NS 1000
`define US_CYC (`US_NS / `CLK_NS)

// Period selection codes
`define SEL_0P8 3'h0
`define SEL_1P7 3'h1
`define SEL_3P5 3'h2
`define SEL_7P1 3'h3
`define SEL_14P2 3'h4
`define SEL_AUTO 3'h5

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_AXES 8'h04
`define OFS_READY 8'h08
`define OFS_STATUS 8'h0C
`define OFS_MEAS 8'h10
`define OFS_ACTIVE 8'h14
`define OFS_LATCH 8'h18

// Control register fields
`define CTRL_SEL_LSB 0
`define CTRL_VIRT_BIT 4
`define CTRL_NOSHORT_BIT 5
`define CTRL_VINV_BIT 6
`define CTRL_RMODE_BIT 7
`define CTRL_ESRC_BIT 8
`define CTRL_RELAY_BIT 9
// Reset values
`define CTRL_RST 16'h0005
`define AXES_RST 6'h01
`define LATCH_RST 32'h0000_0000

`endif

// File: motion_servo_model.sv
// Behavioural compute engine standing behind the cycle scheduler.
// Assumes compute_start is a one-cycle pulse in the pclk domain.
`timescale 1ns/1ps
module motion_servo_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic compute_start,
  input wire logic [15:0] busy_len,
  output logic compute_done
);
  logic [15:0] left;
  // Busy countdown; a start while busy is ignored, like a stalled engine
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      left <= 16'h0000;
      compute_done <= 1'b0;
    end
    else
    begin
      compute_done <= (left == 16'h0001);
      if (left != 16'h0000)
        left <= left - 16'h0001;
      else if (compute_start)
        left <= busy_len;
    end
endmodule // motion_servo_model

// File: test_motion_cycle_ctrl.sv
// Self-checking bench for the motion cycle block with shortened periods.
// Assumes the servo model and checker files are compiled before it.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module test_motion_cycle_ctrl;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, er, compute_start, compute_done, run_ready_flag, axes_stop;
  logic run_switch = 1, external_input_bit = 1, latch_clear_key = 0, latch_erase;
  logic [15:0] busy = 16'h000A, latch_erase_first, latch_erase_last;
  int err_count = 0, cmp_count = 0, g;
  int per[5] = '{50, 100, 200, 400, 800};
  int us[5] = '{888, 1777, 3555, 7111, 14222};
  // Entries: control byte, axis count, expected period index
  logic [23:0] tab[17] = '{24'h0001_00, 24'h0101_01, 24'h0201_02, 24'h0301_03,
    24'h0401_04, 24'h0508_00, 24'h0509_01, 24'h0511_02, 24'h0520_02, 24'h1504_00,
    24'h1505_01, 24'h150D_02, 24'h1519_03, 24'h1520_03, 24'h2001_01, 24'h4101_02,
    24'h4001_02};

  always #4 pclk = ~pclk;

  // Microsecond divider stays at its default, so measured figures are real us
  motion_cycle_ctrl #(.PER0_CYC(50), .PER1_CYC(100), .PER2_CYC(200), .PER3_CYC(400),
    .PER4_CYC(800)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .run_switch, .external_input_bit,
    .latch_clear_key, .compute_done, .compute_start, .run_ready_flag, .axes_stop,
    .latch_erase, .latch_erase_first, .latch_erase_last);
  motion_servo_model srv (.pclk, .presetn, .compute_start, .busy_len(busy), .compute_done);

  task complete_run;
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Hung waits count as a mismatch and end the run
  task tmo;
    err_count++;
    $display("BAD %0t timeout", $time);
    complete_run;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20)
      tmo;
  endtask

  task wstart(output int n);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (compute_start !== 1'b1 && n < 2000);
    if (n >= 2000)
      tmo;
  endtask

  // Sync delay is a few cycles, so a bound of ten is generous
  task ws(input int k, input logic v);
    int n;
    n = 0;
    while ((k == 0 ? run_ready_flag : k == 1 ? axes_stop : latch_erase) !== v && n < 10)
    begin
      @(posedge pclk);
      n++;
    end
    `CHK(n < 10, 1'b1)
  endtask

  task s_reset;
    ws(0, 1);
    apb(0, 8'h00, 0);
    `CHK(rd, 32'h0000_0005)
    apb(0, 8'h04, 0);
    `CHK(rd, 32'h0000_0001)
    apb(0, 8'h0C, 0);
    `CHK(rd[0], 1'b0)
    apb(1, 8'h1C, 32'h0000_0001);
    `CHK(er, 1'b1)
  endtask

  // Third start is measured, since selection lands at a boundary
  task s_period;
    for (int i = 0; i < 17; i++)
    begin
      apb(1, 8'h04, {24'h00_0000, tab[i][15:8]});
      apb(1, 8'h00, {24'h00_0000, tab[i][23:16]});
      repeat (3) wstart(g);
      `CHK(g, per[tab[i][3:0]])
      apb(0, 8'h14, 0);
      `CHK(rd, us[tab[i][3:0]])
    end
  endtask

  task s_over;
    apb(1, 8'h00, 32'h0000_0000);
    busy <= 16'h0050;
    repeat (3) wstart(g);
    apb(0, 8'h0C, 0);
    `CHK(rd[0], 1'b1)
    // 250-cycle computation inside a 400-cycle period: no new overrun
    busy <= 16'h00FA;
    apb(1, 8'h00, 32'h0000_0003); // Period code 3, 7.1 ms, long enough for the computation
    repeat (3) wstart(g);
    apb(0, 8'h0C, 0);
    `CHK(rd[0], 1'b1)
    apb(0, 8'h10, 0);
    `CHK(rd >= 1 && rd <= 3, 1'b1)
  endtask

  task s_ready;
    run_switch <= 0;
    ws(0, 0);
    // Hold stop long enough for the checker to see the fall
    repeat (4) @(posedge pclk);
    run_switch <= 1;
    ws(0, 1);
    apb(1, 8'h00, 32'h0000_0080);
    run_switch <= 0;
    ws(0, 0);
    run_switch <= 1;
    repeat (8) @(posedge pclk);
    `CHK(run_ready_flag, 1'b0)
    apb(1, 8'h08, 32'h0000_0001);
    ws(0, 1);
    apb(1, 8'h08, 32'h0000_0000);
    ws(0, 0);
  endtask

  task s_stop;
    apb(1, 8'h00, 32'h0000_0000); // Pin chosen as stop source
    external_input_bit <= 0;
    ws(1, 1);
    // Hold the stop pin low long enough for the checker to see it
    repeat (4) @(posedge pclk);
    external_input_bit <= 1;
    ws(1, 0);
  endtask

  task s_latch;
    apb(1, 8'h18, 32'h1234_0201);
    apb(0, 8'h18, 0);
    `CHK(rd, 32'h1234_0201)
    `CHK({latch_erase_last, latch_erase_first}, 32'h0002_0001)
    latch_clear_key <= 1;
    ws(2, 1);
    latch_clear_key <= 0;
    // Let the checker see the erase pulse end before the run stops
    repeat (4) @(posedge pclk);
  endtask

  // Main sequence: reset, then one scenario after another
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    s_reset;
    s_period;
    s_over;
    s_ready;
    s_stop;
    s_latch;
    complete_run;
  end
endmodule // test_motion_cycle_ctrl
